// file: design/eis_pkg.sv
// Constants, types and carriers shared by the external interrupt sense and vectoring logic.
// Assumes a single 100 MHz clock domain and an APB register bus with 32-bit data.
package eis_pkg;
    // Register byte offsets
    localparam logic [11:0] ADDR_CTRL = 12'h000;
    localparam logic [11:0] ADDR_CC = 12'h004;
    localparam logic [11:0] ADDR_STAT = 12'h008;

    // Reset values
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] CC_RST = 8'hEA;

    // Control register field positions
    localparam int SENSE_B_LSB = 6;
    localparam int INV_B_BIT = 5;
    localparam int SENSE_A_LSB = 3;
    localparam int INV_A_BIT = 2;
    localparam int EDGE_SEL_BIT = 1;
    localparam int EN_BIT = 0;

    // Condition-code priority bit positions and levels
    localparam int CC_HI_BIT = 5;
    localparam int CC_LO_BIT = 3;
    localparam logic [1:0] PRIO_LVL0 = 2'h2;
    localparam logic [1:0] PRIO_LVL3 = 2'h3;

    // Sensitivity codes
    localparam logic [1:0] SENSE_FALL_LOW = 2'h0;
    localparam logic [1:0] SENSE_RISE = 2'h1;
    localparam logic [1:0] SENSE_FALL = 2'h2;
    localparam logic [1:0] SENSE_BOTH = 2'h3;

    // Vectors and source map
    localparam int NUM_SRC = 14;
    localparam logic [15:0] VEC_RESET = 16'hFFFE;
    localparam logic [15:0] VEC_TRAP = 16'hFFFC;
    localparam logic [15:0] VEC_SRC0 = 16'hFFFA;
    localparam logic [13:0] HALT_WAKE_MASK = 14'h20FD;
    localparam logic [13:0] AHALT_WAKE_MASK = 14'h20FF;

    typedef enum logic [2:0] {
        EIS_OP_ENABLE,
        EIS_OP_DISABLE,
        EIS_OP_HALT,
        EIS_OP_WAIT,
        EIS_OP_POPCC,
        EIS_OP_IRQ_RETURN_INSTR,
        EIS_OP_TRAP,
        EIS_OP_ENTRY
    } eis_op_t;

    typedef struct packed {
        logic valid;
        eis_op_t op;
        logic [7:0] pop_data;
        logic [3:0] src;
        logic [1:0] prio;
    } eis_cpu_req_t;

    typedef struct packed {
        logic req;
        logic [3:0] num;
        logic [15:0] addr;
        logic wake_halt;
        logic wake_active_halt;
    } eis_vec_t;
endpackage

// file: design/eis_sense.sv
// One external port group: pin synchronisers, edge and level detection per sensitivity code.
// Assumes pins are asynchronous to clock; pins of one group are ORed after detection.
`timescale 1ns/1ps
`default_nettype none
module eis_sense #(
    parameter int WIDTH = 4,
    parameter bit CAN_INVERT = 1'b0
) (
    // Clock and reset
    input wire logic clock,
    input wire logic arst_n,
    // Pins and configuration
    input wire logic [WIDTH-1:0] pins,
    input wire logic [1:0] mode,
    input wire logic invert,
    // Detection results
    output logic edge_hit,
    output logic level_req
);
    logic [WIDTH-1:0] sync1;
    logic [WIDTH-1:0] sync2;
    logic [WIDTH-1:0] prev;
    logic want_rise;
    logic want_fall;
    logic want_level;
    logic level_high;
    logic inv;

    // Idle-high reset avoids a spurious edge when pulled-up pins are first seen
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            sync1 <= '1;
            sync2 <= '1;
            prev <= '1;
        end else begin
            sync1 <= pins;
            sync2 <= sync1;
            prev <= sync2;
        end
    end

    assign inv = CAN_INVERT & invert;

    always_comb begin
        want_rise = 1'b0;
        want_fall = 1'b0;
        want_level = 1'b0;
        level_high = 1'b0;
        unique case (mode)
            eis_pkg::SENSE_FALL_LOW: begin
                want_level = 1'b1;
                want_rise = inv;
                want_fall = ~inv;
                level_high = inv;
            end
            eis_pkg::SENSE_RISE: begin
                want_rise = ~inv;
                want_fall = inv;
            end
            eis_pkg::SENSE_FALL: begin
                want_rise = inv;
                want_fall = ~inv;
            end
            eis_pkg::SENSE_BOTH: begin
                want_rise = 1'b1;
                want_fall = 1'b1;
            end
        endcase
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            edge_hit <= 1'b0;
            level_req <= 1'b0;
        end else begin
            edge_hit <= (|(sync2 & ~prev) & want_rise) | (|(~sync2 & prev) & want_fall);
            level_req <= want_level & (level_high ? |sync2 : |(~sync2));
        end
    end
endmodule
`default_nettype wire

// file: design/eis_ctrl.sv
// External interrupt sensitivity control, pending latches, fixed-priority vectoring and
// condition-code software priority tracking. Assumes the CPU core reports dedicated
// instructions and interrupt entries as one-cycle requests on the same clock.
//
// Decided for this implementation: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module eis_ctrl #(
    parameter int ADDR_W = 12
) (
    // Clock and reset
    input wire logic clock,
    input wire logic arst_n,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // External pins
    input wire logic top_level_pin_irq,
    input wire logic [3:0] port_irq_group0,
    input wire logic [2:0] port_irq_group1,
    input wire logic [3:0] port_irq_group2,
    input wire logic [3:0] port_irq_group3,
    // Peripheral requests, same clock; bits 0 and 2..5 are unused
    input wire logic [13:0] periph_irq,
    // CPU core
    input wire eis_pkg::eis_cpu_req_t cpu_req,
    output logic [7:0] cond_code_reg,
    output logic jump_if_masked,
    output logic jump_if_unmasked,
    output eis_pkg::eis_vec_t irq_vec
);
    logic [7:0] ext_int_sense_ctrl;
    logic [3:0] pend_grp;
    logic pend_tli;
    logic [3:0] grp_hit;
    logic [3:0] grp_lvl;
    logic tli_s1;
    logic tli_s2;
    logic tli_prev;
    logic tli_hit;
    logic [1:0] sw_prio;
    logic [1:0] sense_sel_grp_b;
    logic [1:0] sense_sel_grp_a;
    logic invert_port_b_low;
    logic invert_port_a_low;
    logic top_pin_edge_sel;
    logic top_pin_irq_en;
    logic bus_setup;
    logic ctrl_wr;
    logic [7:0] next_ctrl;
    logic sense_change;
    logic [13:0] req_raw;
    logic [13:0] req_live;
    logic [3:0] win_num;
    logic ack_tli;
    logic [3:0] ack_grp;

    assign sw_prio = {cond_code_reg[eis_pkg::CC_HI_BIT], cond_code_reg[eis_pkg::CC_LO_BIT]};
    assign sense_sel_grp_b = ext_int_sense_ctrl[eis_pkg::SENSE_B_LSB +: 2];
    assign sense_sel_grp_a = ext_int_sense_ctrl[eis_pkg::SENSE_A_LSB +: 2];
    assign invert_port_b_low = ext_int_sense_ctrl[eis_pkg::INV_B_BIT];
    assign invert_port_a_low = ext_int_sense_ctrl[eis_pkg::INV_A_BIT];
    assign top_pin_edge_sel = ext_int_sense_ctrl[eis_pkg::EDGE_SEL_BIT];
    assign top_pin_irq_en = ext_int_sense_ctrl[eis_pkg::EN_BIT];

    // APB: zero wait states, read data captured during setup
    assign pready = 1'b1;
    assign bus_setup = psel & ~penable;
    assign ctrl_wr = psel & penable & pwrite & (paddr == ADDR_W'(eis_pkg::ADDR_CTRL));

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (bus_setup) begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
            if (paddr == ADDR_W'(eis_pkg::ADDR_CTRL)) begin
                prdata[7:0] <= ext_int_sense_ctrl;
            end else if (paddr == ADDR_W'(eis_pkg::ADDR_CC)) begin
                prdata[7:0] <= cond_code_reg;
            end else if (paddr == ADDR_W'(eis_pkg::ADDR_STAT)) begin
                prdata[12:0] <= {irq_vec.req, irq_vec.num, 3'h0, pend_grp, pend_tli};
            end else begin
                pslverr <= 1'b1;
            end
        end
    end

    // Write gating: sensitivity and polarity need level 3, the pin edge needs the pin disabled
    always_comb begin
        next_ctrl = ext_int_sense_ctrl;
        if (sw_prio == eis_pkg::PRIO_LVL3) begin
            next_ctrl[7:2] = pwdata[7:2];
        end
        if (!top_pin_irq_en) begin
            next_ctrl[eis_pkg::EDGE_SEL_BIT] = pwdata[eis_pkg::EDGE_SEL_BIT];
        end
        next_ctrl[eis_pkg::EN_BIT] = pwdata[eis_pkg::EN_BIT];
    end

    assign sense_change = ctrl_wr & (next_ctrl[7:2] != ext_int_sense_ctrl[7:2]);

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            ext_int_sense_ctrl <= eis_pkg::CTRL_RST;
        end else if (ctrl_wr) begin
            ext_int_sense_ctrl <= next_ctrl;
        end
    end

    // Port group detectors; only groups 0 and 2 honour inversion
    eis_sense #(.WIDTH(4), .CAN_INVERT(1'b1)) u_grp0 (
        .clock(clock),
        .arst_n(arst_n),
        .pins(port_irq_group0),
        .mode(sense_sel_grp_a),
        .invert(invert_port_a_low),
        .edge_hit(grp_hit[0]),
        .level_req(grp_lvl[0])
    );
    eis_sense #(.WIDTH(3), .CAN_INVERT(1'b0)) u_grp1 (
        .clock(clock),
        .arst_n(arst_n),
        .pins(port_irq_group1),
        .mode(sense_sel_grp_a),
        .invert(invert_port_a_low),
        .edge_hit(grp_hit[1]),
        .level_req(grp_lvl[1])
    );
    eis_sense #(.WIDTH(4), .CAN_INVERT(1'b1)) u_grp2 (
        .clock(clock),
        .arst_n(arst_n),
        .pins(port_irq_group2),
        .mode(sense_sel_grp_b),
        .invert(invert_port_b_low),
        .edge_hit(grp_hit[2]),
        .level_req(grp_lvl[2])
    );
    eis_sense #(.WIDTH(4), .CAN_INVERT(1'b0)) u_grp3 (
        .clock(clock),
        .arst_n(arst_n),
        .pins(port_irq_group3),
        .mode(sense_sel_grp_b),
        .invert(invert_port_b_low),
        .edge_hit(grp_hit[3]),
        .level_req(grp_lvl[3])
    );

    // Top-level pin synchroniser and edge select
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            tli_s1 <= 1'b1;
            tli_s2 <= 1'b1;
            tli_prev <= 1'b1;
        end else begin
            tli_s1 <= top_level_pin_irq;
            tli_s2 <= tli_s1;
            tli_prev <= tli_s2;
        end
    end

    assign tli_hit = top_pin_irq_en & (top_pin_edge_sel ? (tli_s2 & ~tli_prev) : (~tli_s2 & tli_prev));

    // Service entry acknowledges the entered source
    assign ack_tli = cpu_req.valid & (cpu_req.op == eis_pkg::EIS_OP_ENTRY) & (cpu_req.src == 4'h0);
    always_comb begin
        ack_grp = 4'h0;
        for (int g = 0; g < 4; g++) begin
            if (cpu_req.valid && cpu_req.op == eis_pkg::EIS_OP_ENTRY && cpu_req.src == 4'(g + 2)) begin
                ack_grp[g] = 1'b1;
            end
        end
    end

    // A new edge in the clearing cycle wins over the clear
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            pend_grp <= 4'h0;
        end else begin
            pend_grp <= grp_hit | (pend_grp & ~ack_grp & ~{4{sense_change}});
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            pend_tli <= 1'b0;
        end else begin
            pend_tli <= tli_hit | (pend_tli & ~ack_tli & top_pin_irq_en);
        end
    end

    // Condition-code register and software priority
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            cond_code_reg <= eis_pkg::CC_RST;
        end else if (cpu_req.valid) begin
            unique case (cpu_req.op)
                eis_pkg::EIS_OP_ENABLE, eis_pkg::EIS_OP_HALT, eis_pkg::EIS_OP_WAIT: begin
                    cond_code_reg[eis_pkg::CC_HI_BIT] <= eis_pkg::PRIO_LVL0[1];
                    cond_code_reg[eis_pkg::CC_LO_BIT] <= eis_pkg::PRIO_LVL0[0];
                end
                eis_pkg::EIS_OP_DISABLE, eis_pkg::EIS_OP_TRAP: begin
                    cond_code_reg[eis_pkg::CC_HI_BIT] <= eis_pkg::PRIO_LVL3[1];
                    cond_code_reg[eis_pkg::CC_LO_BIT] <= eis_pkg::PRIO_LVL3[0];
                end
                eis_pkg::EIS_OP_POPCC, eis_pkg::EIS_OP_IRQ_RETURN_INSTR: begin
                    cond_code_reg <= cpu_req.pop_data;
                end
                eis_pkg::EIS_OP_ENTRY: begin
                    if (cpu_req.src == 4'h0) begin
                        cond_code_reg[eis_pkg::CC_HI_BIT] <= eis_pkg::PRIO_LVL3[1];
                        cond_code_reg[eis_pkg::CC_LO_BIT] <= eis_pkg::PRIO_LVL3[0];
                    end else begin
                        cond_code_reg[eis_pkg::CC_HI_BIT] <= cpu_req.prio[1];
                        cond_code_reg[eis_pkg::CC_LO_BIT] <= cpu_req.prio[0];
                    end
                end
            endcase
        end
    end

    assign jump_if_masked = (sw_prio == eis_pkg::PRIO_LVL3);
    assign jump_if_unmasked = ~jump_if_masked;

    // Source map and fixed priority: lowest number wins
    assign req_raw = {periph_irq[13:6], pend_grp | grp_lvl, periph_irq[1], pend_tli};
    assign req_live = jump_if_masked ? {13'h0000, req_raw[0]} : req_raw;

    always_comb begin
        win_num = 4'h0;
        for (int i = eis_pkg::NUM_SRC - 1; i >= 0; i--) begin
            if (req_live[i]) begin
                win_num = 4'(i);
            end
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            irq_vec <= '0;
        end else begin
            irq_vec.req <= |req_live;
            irq_vec.num <= win_num;
            irq_vec.addr <= eis_pkg::VEC_SRC0 - {11'h000, win_num, 1'b0};
            irq_vec.wake_halt <= |(req_raw & eis_pkg::HALT_WAKE_MASK);
            irq_vec.wake_active_halt <= |(req_raw & eis_pkg::AHALT_WAKE_MASK);
        end
    end

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!arst_n);

    sequence s_op(eis_pkg::eis_op_t o);
        cpu_req.valid && cpu_req.op == o;
    endsequence
    sequence s_edge_seen(int g);
        grp_hit[g] ##1 pend_grp[g];
    endsequence

    a_enable_lvl0: assert property (s_op(eis_pkg::EIS_OP_ENABLE) |=> sw_prio == 2'h2)
        else $error("enable not level 0");
    a_disable_lvl3: assert property (s_op(eis_pkg::EIS_OP_DISABLE) |=> sw_prio == 2'h3 && jump_if_masked)
        else $error("disable not level 3");
    a_jump_pair: assert property (jump_if_masked != jump_if_unmasked &&
        (jump_if_masked == (cond_code_reg[5] & cond_code_reg[3])))
        else $error("jump flags wrong");
    a_pop_restore: assert property (s_op(eis_pkg::EIS_OP_POPCC) |=> cond_code_reg == $past(cpu_req.pop_data))
        else $error("pop did not restore");
    a_prio_holds: assert property (!cpu_req.valid |=> $stable(cond_code_reg))
        else $error("priority changed idle");
    a_vec_addr: assert property (irq_vec.req |-> irq_vec.addr == 16'hFFFA - {11'h000, irq_vec.num, 1'b0})
        else $error("bad vector address");
    a_tli_first: assert property (pend_tli && top_pin_irq_en |=> irq_vec.req && irq_vec.num == 4'h0)
        else $error("pin not top priority");
    a_no_wake_slow: assert property ((req_raw & 14'h20FF) == 14'h0000 |=>
        !irq_vec.wake_halt && !irq_vec.wake_active_halt)
        else $error("non-wake source woke");
    a_src1_ahalt: assert property (req_raw == 14'h0002 |=> irq_vec.wake_active_halt && !irq_vec.wake_halt)
        else $error("source 1 wake wrong");
    a_change_clear: assert property (sense_change && grp_hit == 4'h0 |=> pend_grp == 4'h0)
        else $error("pending not cleared");
    a_locked_sense: assert property (ctrl_wr && sw_prio != 2'h3 |=> $stable(ext_int_sense_ctrl[7:2]))
        else $error("sense written unlocked");
    a_edge_latched: assert property (s_edge_seen(0) ##0 (!ack_grp[0] && !sense_change) |=> pend_grp[0])
        else $error("edge pending lost");
endmodule
`default_nettype wire

// file: test/eis_cpu_model.sv
// CPU core model: reports dedicated instructions and interrupt entries to the block.
// Assumes the block takes cpu_req at the rising clock edge while valid is high.
`timescale 1ns/1ps
`default_nettype none
module eis_cpu_model (
    // Clock
    input wire logic clock,
    // Report to the block
    output eis_pkg::eis_cpu_req_t cpu_req
);
    initial cpu_req = '0;

    // One report per call; valid is low for a cycle between calls so no edge is shared
    task automatic issue(input eis_pkg::eis_op_t op, input logic [7:0] data, input logic [3:0] src,
        input logic [1:0] prio);
        @(posedge clock);
        cpu_req <= '{valid: 1'b1, op: op, pop_data: data, src: src, prio: prio};
        @(posedge clock);
        cpu_req <= '0;
    endtask
endmodule
`default_nettype wire

// file: test/test_ext_interrupt_sense_and_vectoring.sv
// Self-checking bench for the external interrupt sense and vectoring block.
// Assumes eis_cpu_model stands in for the core; pins and peripheral lines are driven here.
`timescale 1ns/1ps
`default_nettype none
module test_ext_interrupt_sense_and_vectoring;
    logic clock = 1'b0;
    logic arst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic top_level_pin_irq = 1'b1;
    // Groups 0..3 packed as [3:0], [6:4], [10:7], [14:11]
    logic [14:0] grp = '1;
    logic [13:0] periph = 14'h0000;
    eis_pkg::eis_cpu_req_t cpu_req;
    logic [7:0] cond_code_reg;
    logic jump_if_masked;
    logic jump_if_unmasked;
    eis_pkg::eis_vec_t irq_vec;
    int n_fail = 0;
    int compares = 0;
    logic [31:0] rd;
    logic err;

    always #5 clock = ~clock;

    eis_ctrl #(.ADDR_W(12)) dut (.clock(clock), .arst_n(arst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .top_level_pin_irq(top_level_pin_irq), .port_irq_group0(grp[3:0]),
        .port_irq_group1(grp[6:4]), .port_irq_group2(grp[10:7]), .port_irq_group3(grp[14:11]),
        .periph_irq(periph), .cpu_req(cpu_req), .cond_code_reg(cond_code_reg),
        .jump_if_masked(jump_if_masked), .jump_if_unmasked(jump_if_unmasked), .irq_vec(irq_vec));

    eis_cpu_model cpu (.clock(clock), .cpu_req(cpu_req));

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
        int i;
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h00_0000, d};
        @(posedge clock);
        penable <= 1'b1;
        for (i = 0; i < 16; i++) begin
            @(posedge clock);
            if (pready === 1'b1) break;
        end
        rd = prdata;
        err = pslverr;
        if (i == 16) begin
            n_fail++;
            summarize();
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wait_req(input logic exp);
        int i;
        for (i = 0; i < 12; i++) begin
            @(negedge clock);
            if (irq_vec.req === exp) break;
        end
        if (i == 12) begin
            n_fail++;
            summarize();
        end
    endtask

    task automatic chk_vec(input int n, input logic wh, input logic wa);
        wait_req(1'b1);
        chk(16'(irq_vec.num), 16'(n));
        chk(irq_vec.addr, 16'hFFFA - 16'(2 * n));
        chk(16'({irq_vec.wake_halt, irq_vec.wake_active_halt}), 16'({wh, wa}));
    endtask

    // Priority field after each instruction; both jump flags after enable, disable, halt, wait and trap, unmasked flag after pop
    task automatic s_instr();
        eis_pkg::eis_op_t ops[5] = '{eis_pkg::EIS_OP_ENABLE, eis_pkg::EIS_OP_DISABLE, eis_pkg::EIS_OP_HALT,
            eis_pkg::EIS_OP_WAIT, eis_pkg::EIS_OP_TRAP};
        logic [1:0] lv[5] = '{2'h2, 2'h3, 2'h2, 2'h2, 2'h3};
        for (int i = 0; i < 5; i++) begin
            cpu.issue(ops[i], 8'h00, 4'h0, 2'h0);
            @(negedge clock);
            chk(16'({cond_code_reg[5], cond_code_reg[3], jump_if_masked, jump_if_unmasked}),
                16'({lv[i], lv[i] == 2'h3, lv[i] != 2'h3}));
        end
        cpu.issue(eis_pkg::EIS_OP_POPCC, 8'h55, 4'h0, 2'h0);
        @(negedge clock);
        chk(16'({cond_code_reg, jump_if_unmasked}), 16'h00AB);
        cpu.issue(eis_pkg::EIS_OP_IRQ_RETURN_INSTR, 8'hEA, 4'h0, 2'h0);
        @(negedge clock);
        chk(16'(cond_code_reg), 16'h00EA);
    endtask

    // Sensitivity bits only land at level 3; read back after a write at level 0 and at level 3
    task automatic s_lock();
        cpu.issue(eis_pkg::EIS_OP_ENABLE, 8'h00, 4'h0, 2'h0);
        apb(1'b1, eis_pkg::ADDR_CTRL, 8'hFC);
        apb(1'b0, eis_pkg::ADDR_CTRL, 8'h00);
        chk(rd[15:0], 16'h0000);
        cpu.issue(eis_pkg::EIS_OP_DISABLE, 8'h00, 4'h0, 2'h0);
        apb(1'b1, eis_pkg::ADDR_CTRL, 8'hFC);
        apb(1'b0, eis_pkg::ADDR_CTRL, 8'h00);
        chk(rd[15:0], 16'h00FC);
    endtask

    function automatic logic hit(input logic [1:0] c, input logic inv, input logic rise);
        return c == 2'h3 || ((c == 2'h1) ? rise != inv : rise == inv);
    endfunction

    // One code and polarity: fall then rise on every group, pending seen in status
    task automatic s_sense(input logic [1:0] c, input logic inv);
        logic [3:0] f;
        logic [3:0] r;
        f = {hit(c, 1'b0, 1'b0), hit(c, inv, 1'b0), hit(c, 1'b0, 1'b0), hit(c, inv, 1'b0)};
        r = {hit(c, 1'b0, 1'b1), hit(c, inv, 1'b1), hit(c, 1'b0, 1'b1), hit(c, inv, 1'b1)};
        apb(1'b1, eis_pkg::ADDR_CTRL, {c, inv, c, inv, 2'b00});
        apb(1'b0, eis_pkg::ADDR_STAT, 8'h00);
        chk(16'(rd[4:1]), 16'h0000);
        grp <= '0;
        repeat (6) @(posedge clock);
        apb(1'b0, eis_pkg::ADDR_STAT, 8'h00);
        chk(16'(rd[4:1]), 16'(f));
        for (int s = 2; s < 6; s++) begin
            cpu.issue(eis_pkg::EIS_OP_ENTRY, 8'h00, 4'(s), 2'h3);
        end
        grp <= '1;
        repeat (6) @(posedge clock);
        apb(1'b1, eis_pkg::ADDR_CTRL, {c, inv, c, inv, 2'b00});
        apb(1'b0, eis_pkg::ADDR_STAT, 8'h00);
        chk(16'(rd[4:1]), 16'(r));
    endtask

    // Top pin is served even at level 3; edge select is locked while enabled
    task automatic s_top();
        apb(1'b1, eis_pkg::ADDR_CTRL, 8'h01);
        apb(1'b1, eis_pkg::ADDR_CTRL, 8'h03);
        apb(1'b0, eis_pkg::ADDR_CTRL, 8'h00);
        chk(rd[15:0], 16'h0001);
        top_level_pin_irq <= 1'b0;
        chk_vec(0, 1'b1, 1'b1);
        cpu.issue(eis_pkg::EIS_OP_ENTRY, 8'h00, 4'h0, 2'h0);
        wait_req(1'b0);
        chk(16'(cond_code_reg & 8'h28), 16'h0028);
        @(posedge clock);
        top_level_pin_irq <= 1'b1;
    endtask

    // Port groups and peripheral lines: numbers, vectors and wake capability
    task automatic s_map();
        int gb[4] = '{0, 4, 7, 11};
        int ns[9] = '{1, 6, 7, 8, 9, 10, 11, 12, 13};
        cpu.issue(eis_pkg::EIS_OP_ENABLE, 8'h00, 4'h0, 2'h0);
        foreach (gb[k]) begin
            @(posedge clock);
            grp[gb[k]] <= 1'b0;
            chk_vec(2 + k, 1'b1, 1'b1);
            @(posedge clock);
            grp[gb[k]] <= 1'b1;
            cpu.issue(eis_pkg::EIS_OP_ENTRY, 8'h00, 4'(2 + k), 2'h2);
            wait_req(1'b0);
        end
        foreach (ns[i]) begin
            @(posedge clock);
            periph <= 14'(1 << ns[i]);
            chk_vec(ns[i], ns[i] inside {6, 7, 13}, ns[i] inside {1, 6, 7, 13});
            @(posedge clock);
            periph <= '0;
            wait_req(1'b0);
        end
        @(posedge clock);
        periph <= 14'h0102;
        chk_vec(1, 1'b0, 1'b1);
        cpu.issue(eis_pkg::EIS_OP_DISABLE, 8'h00, 4'h0, 2'h0);
        wait_req(1'b0);
        chk(16'(irq_vec.req), 16'h0000);
        @(posedge clock);
        periph <= '0;
    endtask

    initial begin
        repeat (10) @(posedge clock);
        arst_n <= 1'b1;
        @(negedge clock);
        chk(16'({cond_code_reg, jump_if_masked}), 16'h01D5);
        apb(1'b0, eis_pkg::ADDR_CTRL, 8'h00);
        chk(rd[15:0], 16'h0000);
        apb(1'b1, eis_pkg::ADDR_CC, 8'h00);
        apb(1'b0, eis_pkg::ADDR_CC, 8'h00);
        chk(rd[15:0], 16'h00EA);
        apb(1'b0, 12'h0FC, 8'h00);
        chk(16'({err, rd[7:0]}), 16'h0100);
        s_instr();
        s_lock();
        for (int c = 0; c < 4; c++) begin
            s_sense(2'(c), 1'b0);
            s_sense(2'(c), 1'b1);
        end
        s_top();
        s_map();
        summarize();
    end
endmodule
`default_nettype wire
